/* hdl/irq_enable_top.sv */
// Interrupt enable words, request gating, status and summary interrupt.
//
// The register offsets and strobed register access were left to the implementer.
`timescale 1ns/100ps
// How it works
// - Word 0 bit 1 gates capture 1.
// - Word 0 bit 0 gates external pin 0.
// - Word 1 bit 4 gates external pin 1.
// - Word 1 bit 3 gates pin change.
// - Word 1 bit 1 gates two-wire master.
module irq_enable_top
    import irq_enable_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic [ADDR_W-1:0]    reg_addr,
    input  wire logic [DATA_W-1:0]    reg_wdata,
    input  wire logic                 reg_wr,
    input  wire logic                 reg_rd,
    output logic      [DATA_W-1:0]    reg_rdata,
    input  wire logic [SRC_COUNT-1:0] irq_req_in,
    output logic      [SRC_COUNT-1:0] irq_req_out,
    output logic                      irq
);
    function automatic logic hit(input logic [ADDR_W-1:0] a,
                                 input logic [ADDR_W-1:0] off);
        hit = (a == off);
    endfunction

    logic [DATA_W-1:0]    word0_r;
    logic [DATA_W-1:0]    word1_r;
    logic [SRC_COUNT-1:0] mask_r;
    logic [DATA_W-1:0]    rdata_r;
    logic [DATA_W-1:0]    rdata_nxt;
    logic [SRC_COUNT-1:0] enable;
    logic                 wr_w0;
    logic                 wr_w1;
    logic                 wr_mask;
    logic                 rd_status;

    irq_path_if #(.N(SRC_COUNT)) path ();

    assign wr_w0     = reg_wr && hit(reg_addr, OFF_ENABLE0);
    assign wr_w1     = reg_wr && hit(reg_addr, OFF_ENABLE1);
    assign wr_mask   = reg_wr && hit(reg_addr, OFF_MASK);
    assign rd_status = reg_rd && hit(reg_addr, OFF_STATUS);

    // Only the status bits actually returned by the read are cleared.
    assign path.clr = rd_status ? path.status : STATUS_RESET;

    // Enable fields routed to each source position.
    assign enable[SRC_CAP1]   = word0_r[W0_CAP1_BIT];
    assign enable[SRC_EXT0]   = word0_r[W0_EXT0_BIT];
    assign enable[SRC_EXT1]   = word1_r[W1_EXT1_BIT];
    assign enable[SRC_PINCHG] = word1_r[W1_PINCHG_BIT];
    assign enable[SRC_TWM]    = word1_r[W1_TWM_BIT];
    assign enable[SRC_EXT2]   = word1_r[W1_EXT2_BIT];
    assign enable[SRC_CMP1]   = word1_r[W1_CMP1_BIT];
    assign enable[SRC_TWS]    = word1_r[W1_TWS_BIT];

    // Unimplemented positions never hold state, so they read zero.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            word0_r <= ENABLE_RESET;
            word1_r <= ENABLE_RESET;
            mask_r  <= MASK_RESET;
        end else begin
            if (wr_w0) begin
                word0_r <= reg_wdata & ENABLE0_IMPL;
            end
            if (wr_w1) begin
                word1_r <= reg_wdata & ENABLE1_IMPL;
            end
            if (wr_mask) begin
                mask_r <= reg_wdata[SRC_COUNT-1:0];
            end
        end
    end

    assign rdata_nxt =
        !reg_rd                        ? ENABLE_RESET :
        hit(reg_addr, OFF_ENABLE0)     ? word0_r :
        hit(reg_addr, OFF_ENABLE1)     ? word1_r :
        hit(reg_addr, OFF_STATUS)      ?
            {{(DATA_W-SRC_COUNT){1'b0}}, path.status} :
        hit(reg_addr, OFF_MASK)        ?
            {{(DATA_W-SRC_COUNT){1'b0}}, mask_r} :
        ENABLE_RESET;

    // Read data stand only in the cycle after the strobe.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            rdata_r <= ENABLE_RESET;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    enable_gate #(.N(SRC_COUNT)) u_gate (
        .clk_sys (clk_sys),
        .reset   (reset),
        .req_in  (irq_req_in),
        .enable  (enable),
        .path    (path.gate_mp)
    );

    sticky_status #(.N(SRC_COUNT)) u_status (
        .clk_sys (clk_sys),
        .reset   (reset),
        .path    (path.stat_mp)
    );

    assign irq_req_out = path.gated;
    assign irq         = |(path.status & mask_r);

    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (reset);

    property p_cap1_gate;
        irq_req_in[SRC_CAP1] |=>
            (irq_req_out[SRC_CAP1] == $past(word0_r[W0_CAP1_BIT]));
    endproperty
    a_cap1_gate: assert property (p_cap1_gate)
        else $error("capture 1 request not gated by word 0 bit 1");

    property p_ext0_block;
        !word0_r[W0_EXT0_BIT] |=> !irq_req_out[SRC_EXT0];
    endproperty
    a_ext0_block: assert property (p_ext0_block)
        else $error("external pin 0 request passed while disabled");

    property p_ext1_pass;
        (word1_r[W1_EXT1_BIT] && irq_req_in[SRC_EXT1])
            |=> irq_req_out[SRC_EXT1];
    endproperty
    a_ext1_pass: assert property (p_ext1_pass)
        else $error("external pin 1 request lost while enabled");

    property p_pinchg_gate;
        wr_w1 ##1 irq_req_in[SRC_PINCHG][*2] |=>
            (irq_req_out[SRC_PINCHG] == $past(word1_r[W1_PINCHG_BIT]));
    endproperty
    a_pinchg_gate: assert property (p_pinchg_gate)
        else $error("pin change request disagrees with word 1 bit 3");

    property p_twm_write;
        (wr_w1 && !reg_wdata[W1_TWM_BIT]) |=> ##1 !irq_req_out[SRC_TWM];
    endproperty
    a_twm_write: assert property (p_twm_write)
        else $error("master event passed after its enable was cleared");

    property p_w1_unimpl;
        (reg_rd && hit(reg_addr, OFF_ENABLE1)) |=>
            ((reg_rdata & ~ENABLE1_IMPL) == ENABLE_RESET);
    endproperty
    a_w1_unimpl: assert property (p_w1_unimpl)
        else $error("unimplemented word 1 bit read as one");

    property p_reset_zero;
        @(posedge clk_sys) disable iff (1'b0)
        reset |=> (word0_r == ENABLE_RESET && word1_r == ENABLE_RESET);
    endproperty
    a_reset_zero: assert property (p_reset_zero)
        else $error("enable word not zero after reset");

    property p_ext2_cmp_tws;
        !word1_r[W1_EXT2_BIT] && !word1_r[W1_CMP1_BIT]
            && !word1_r[W1_TWS_BIT] |=>
            !irq_req_out[SRC_EXT2] && !irq_req_out[SRC_CMP1]
            && !irq_req_out[SRC_TWS];
    endproperty
    a_ext2_cmp_tws: assert property (p_ext2_cmp_tws)
        else $error("disabled word 1 source reached the CPU");

    property p_read_clears;
        (rd_status && path.rise == STATUS_RESET) |=>
            ((path.status & $past(path.status)) == STATUS_RESET);
    endproperty
    a_read_clears: assert property (p_read_clears)
        else $error("status read did not clear the returned bits");

    property p_irq_follows;
        |(path.rise & mask_r) && !wr_mask |=> irq;
    endproperty
    a_irq_follows: assert property (p_irq_follows)
        else $error("unmasked event did not raise the interrupt");

    property p_cap1_block;
        !word0_r[W0_CAP1_BIT] |=> !irq_req_out[SRC_CAP1];
    endproperty
    a_cap1_block: assert property (p_cap1_block)
        else $error("capture 1 request passed while disabled");

    property p_ext0_pass;
        (word0_r[W0_EXT0_BIT] && irq_req_in[SRC_EXT0])
            |=> irq_req_out[SRC_EXT0];
    endproperty
    a_ext0_pass: assert property (p_ext0_pass)
        else $error("external pin 0 request lost while enabled");

    property p_ext1_block;
        !word1_r[W1_EXT1_BIT] |=> !irq_req_out[SRC_EXT1];
    endproperty
    a_ext1_block: assert property (p_ext1_block)
        else $error("external pin 1 request passed while disabled");

    property p_pinchg_pass;
        (word1_r[W1_PINCHG_BIT] && irq_req_in[SRC_PINCHG])
            |=> irq_req_out[SRC_PINCHG];
    endproperty
    a_pinchg_pass: assert property (p_pinchg_pass)
        else $error("pin change request lost while enabled");

    property p_twm_pass;
        (word1_r[W1_TWM_BIT] && irq_req_in[SRC_TWM])
            |=> irq_req_out[SRC_TWM];
    endproperty
    a_twm_pass: assert property (p_twm_pass)
        else $error("master event lost while enabled");

    property p_ext2_pass;
        (word1_r[W1_EXT2_BIT] && irq_req_in[SRC_EXT2])
            |=> irq_req_out[SRC_EXT2];
    endproperty
    a_ext2_pass: assert property (p_ext2_pass)
        else $error("external pin 2 request lost while enabled");

    property p_cmp1_pass;
        (word1_r[W1_CMP1_BIT] && irq_req_in[SRC_CMP1])
            |=> irq_req_out[SRC_CMP1];
    endproperty
    a_cmp1_pass: assert property (p_cmp1_pass)
        else $error("comparator 1 request lost while enabled");

    property p_tws_pass;
        (word1_r[W1_TWS_BIT] && irq_req_in[SRC_TWS])
            |=> irq_req_out[SRC_TWS];
    endproperty
    a_tws_pass: assert property (p_tws_pass)
        else $error("slave event lost while enabled");

    property p_w0_unimpl;
        (reg_rd && hit(reg_addr, OFF_ENABLE0)) |=>
            ((reg_rdata & ~ENABLE0_IMPL) == ENABLE_RESET);
    endproperty
    a_w0_unimpl: assert property (p_w0_unimpl)
        else $error("unimplemented word 0 bit read as one");

    property p_w1_write;
        wr_w1 |=> (word1_r == ($past(reg_wdata) & ENABLE1_IMPL));
    endproperty
    a_w1_write: assert property (p_w1_write)
        else $error("word 1 write did not keep exactly its fields");

    property p_mask_write;
        wr_mask |=> (mask_r == $past(reg_wdata[SRC_COUNT-1:0]));
    endproperty
    a_mask_write: assert property (p_mask_write)
        else $error("mask write did not land");

    property p_unmapped_write;
        (reg_wr && !wr_w0 && !wr_w1 && !wr_mask) |=>
            ($stable(word0_r) && $stable(word1_r) && $stable(mask_r));
    endproperty
    a_unmapped_write: assert property (p_unmapped_write)
        else $error("write to an unmapped address changed a register");

    // Read data must not linger, or an idle sample would alias it.
    property p_rdata_idle;
        !reg_rd |=> (reg_rdata == ENABLE_RESET);
    endproperty
    a_rdata_idle: assert property (p_rdata_idle)
        else $error("read data stood beyond the cycle after the read");

    property p_status_sets;
        (path.rise != STATUS_RESET) |=>
            ((path.status & $past(path.rise)) == $past(path.rise));
    endproperty
    a_status_sets: assert property (p_status_sets)
        else $error("gated request edge did not set its status bit");

    property p_set_wins;
        (rd_status && path.rise != STATUS_RESET) |=>
            (path.status == $past(path.rise));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("event in the clearing read was lost");

    property p_reset_outputs;
        @(posedge clk_sys) disable iff (1'b0)
        reset |=> (irq_req_out == STATUS_RESET && !irq
                   && reg_rdata == ENABLE_RESET);
    endproperty
    a_reset_outputs: assert property (p_reset_outputs)
        else $error("an output was not zero after reset");

    c_enable_pass: cover property (wr_w0 ##1 irq_req_in[SRC_CAP1]
                                   ##1 irq_req_out[SRC_CAP1]);
    c_irq_raise:   cover property (!irq ##1 irq);
    c_read_clear:  cover property (irq ##0 rd_status ##1 !irq);
    c_set_wins:    cover property (rd_status && path.rise != STATUS_RESET);
    c_unmapped_wr: cover property (reg_wr && !wr_w0 && !wr_w1 && !wr_mask);
endmodule

/* hdl/irq_enable_pkg.sv */
// Shared offsets, bit positions, reset values and source indices.
package irq_enable_pkg;

    localparam int DATA_W    = 16;
    localparam int ADDR_W    = 4;
    localparam int SRC_COUNT = 8;

    // Register offsets on the plain register port.
    localparam logic [ADDR_W-1:0] OFF_ENABLE0 = 4'h0;
    localparam logic [ADDR_W-1:0] OFF_ENABLE1 = 4'h2;
    localparam logic [ADDR_W-1:0] OFF_STATUS  = 4'h4;
    localparam logic [ADDR_W-1:0] OFF_MASK    = 4'h6;

    // Field positions inside interrupt_enable_word_0.
    localparam int W0_EXT0_BIT = 0;
    localparam int W0_CAP1_BIT = 1;

    // Field positions inside interrupt_enable_word_1.
    localparam int W1_TWS_BIT    = 0;
    localparam int W1_TWM_BIT    = 1;
    localparam int W1_CMP1_BIT   = 2;
    localparam int W1_PINCHG_BIT = 3;
    localparam int W1_EXT1_BIT   = 4;
    localparam int W1_EXT2_BIT   = 13;

    // Bits that hold state; every other bit reads as zero.
    localparam logic [DATA_W-1:0] ENABLE0_IMPL = 16'h0003;
    localparam logic [DATA_W-1:0] ENABLE1_IMPL = 16'h201f;
    localparam logic [DATA_W-1:0] ENABLE_RESET = 16'h0000;

    // Source order used by request pins, status and mask registers.
    localparam int SRC_EXT0   = 0;
    localparam int SRC_CAP1   = 1;
    localparam int SRC_TWS    = 2;
    localparam int SRC_TWM    = 3;
    localparam int SRC_CMP1   = 4;
    localparam int SRC_PINCHG = 5;
    localparam int SRC_EXT1   = 6;
    localparam int SRC_EXT2   = 7;

    localparam logic [SRC_COUNT-1:0] STATUS_RESET = 8'h00;
    localparam logic [SRC_COUNT-1:0] MASK_RESET   = 8'h00;

endpackage

/* hdl/irq_path_if.sv */
// Carrier between the gating stage, the status store and the top.
`timescale 1ns/100ps
interface irq_path_if #(parameter int N = 8);
    logic [N-1:0] gated;
    logic [N-1:0] rise;
    logic [N-1:0] status;
    logic [N-1:0] clr;

    modport gate_mp (output gated, output rise);
    modport stat_mp (input rise, input clr, output status);
    modport top_mp  (input gated, input rise, input status, output clr);
endinterface

/* hdl/enable_gate.sv */
// Per-source request gating with rising-edge event detection.
`timescale 1ns/100ps
module enable_gate
    import irq_enable_pkg::*;
#(
    parameter int N = SRC_COUNT
) (
    input  wire logic         clk_sys,
    input  wire logic         reset,
    input  wire logic [N-1:0] req_in,
    input  wire logic [N-1:0] enable,
    irq_path_if.gate_mp       path
);
    logic [N-1:0] pass;
    logic [N-1:0] gated_r;
    logic [N-1:0] prev_r;

    genvar i;
    generate
        for (i = 0; i < N; i++) begin : g_src
            assign pass[i] = req_in[i] & enable[i];
        end
    endgenerate

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            gated_r <= STATUS_RESET[N-1:0];
            prev_r  <= STATUS_RESET[N-1:0];
        end else begin
            gated_r <= pass;
            prev_r  <= gated_r;
        end
    end

    // A request held high counts as one event, not one per cycle.
    assign path.gated = gated_r;
    assign path.rise  = gated_r & ~prev_r;
endmodule

/* hdl/sticky_status.sv */
// Sticky event status bits cleared by a status read.
`timescale 1ns/100ps
module sticky_status
    import irq_enable_pkg::*;
#(
    parameter int N = SRC_COUNT
) (
    input  wire logic   clk_sys,
    input  wire logic   reset,
    irq_path_if.stat_mp path
);
    logic [N-1:0] status_r;
    logic [N-1:0] status_nxt;

    // A new event in the clearing cycle survives: set wins over clear.
    assign status_nxt = (status_r & ~path.clr) | path.rise;

    always_ff @(posedge clk_sys) begin
        if (reset) begin
            status_r <= STATUS_RESET[N-1:0];
        end else begin
            status_r <= status_nxt;
        end
    end

    assign path.status = status_r;
endmodule

/* verif/irq_source_model.sv */
// Model of the request sources and the CPU side of the enable block.
`timescale 1ns/100ps
module irq_source_model
    import irq_enable_pkg::*;
(
    input  wire logic                 clk_sys,
    input  wire logic                 reset,
    input  wire logic [SRC_COUNT-1:0] level_cmd,
    input  wire logic [SRC_COUNT-1:0] irq_req_out,
    input  wire logic                 irq,
    output logic      [SRC_COUNT-1:0] irq_req_in,
    output int                        irq_cycles,
    output int                        stray_cycles
);
    logic [SRC_COUNT-1:0] req_prev_r;

    // Sources change only after a clock edge, like real flag logic.
    always_ff @(posedge clk_sys) begin
        if (reset) begin
            irq_req_in   <= '0;
            req_prev_r   <= '0;
            irq_cycles   <= 0;
            stray_cycles <= 0;
        end else begin
            irq_req_in   <= level_cmd;
            req_prev_r   <= irq_req_in;
            irq_cycles   <= irq_cycles + int'(irq);
            // A forwarded bit must have been requested one edge earlier.
            stray_cycles <= stray_cycles
                            + int'(|(irq_req_out & ~req_prev_r));
        end
    end
endmodule

/* verif/irq_enable_top_tb.sv */
// Self-checking bench for the interrupt enable block.
`timescale 1ns/100ps
module irq_enable_top_tb
    import irq_enable_pkg::*;
;
    logic                 clk_sys;
    logic                 reset;
    logic [ADDR_W-1:0]    reg_addr;
    logic [DATA_W-1:0]    reg_wdata;
    logic                 reg_wr;
    logic                 reg_rd;
    logic [DATA_W-1:0]    reg_rdata;
    logic [SRC_COUNT-1:0] irq_req_in;
    logic [SRC_COUNT-1:0] irq_req_out;
    logic                 irq;
    logic [SRC_COUNT-1:0] level_cmd;
    int                   irq_cycles;
    int                   stray_cycles;
    int                   n_errors;
    int                   comparisons;
    // Source index to enable word and bit position.
    int wsel [8] = '{0, 0, 1, 1, 1, 1, 1, 1};
    int wbit [8] = '{W0_EXT0_BIT, W0_CAP1_BIT, W1_TWS_BIT, W1_TWM_BIT,
                     W1_CMP1_BIT, W1_PINCHG_BIT, W1_EXT1_BIT, W1_EXT2_BIT};

    irq_enable_top u_dut (.clk_sys(clk_sys), .reset(reset),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_rdata(reg_rdata), .irq_req_in(irq_req_in),
        .irq_req_out(irq_req_out), .irq(irq));
    irq_source_model u_src (.clk_sys(clk_sys), .reset(reset),
        .level_cmd(level_cmd), .irq_req_out(irq_req_out), .irq(irq),
        .irq_req_in(irq_req_in), .irq_cycles(irq_cycles),
        .stray_cycles(stray_cycles));

    initial begin
        clk_sys = 1'b0;
        forever #2.5 clk_sys = ~clk_sys;
    end

    task automatic final_report();
        $display("errors %0d comparisons %0d", n_errors, comparisons);
        if (n_errors == 0 && comparisons > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask

    task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic chk8(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_errors++;
            $display("wrong value at %0t: got %h expected %h",
                     $time, got, exp);
        end
    endtask

    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr    <= 1'b0;
    endtask

    // Read data stand only in the cycle after the strobe.
    task automatic rd(input logic [3:0] a, input logic [15:0] exp);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd   <= 1'b0;
        #1;
        chk16(reg_rdata, exp);
    endtask

    task automatic settle();
        repeat (3) @(posedge clk_sys);
        #1;
    endtask

    initial begin
        #20000;
        n_errors++;
        final_report();
    end

    initial begin
        reset = 1'b1;
        reg_addr = '0;
        reg_wdata = '0;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        level_cmd = '0;
        n_errors = 0;
        comparisons = 0;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(OFF_ENABLE0, 16'h0000);
        rd(OFF_ENABLE1, 16'h0000);
        wr(OFF_ENABLE0, 16'hffff);
        wr(OFF_ENABLE1, 16'hffff);
        wr(4'h8, 16'hffff);
        rd(OFF_ENABLE0, 16'h0003);
        rd(OFF_ENABLE1, 16'h201f);
        rd(4'h8, 16'h0000);
        wr(OFF_ENABLE0, 16'h0000);
        wr(OFF_ENABLE1, 16'h0000);
        level_cmd <= 8'hff;
        settle();
        chk8(irq_req_out, 8'h00);
        // Walk one enable bit across every source with all requests up.
        for (int i = 0; i < SRC_COUNT; i++) begin
            wr(OFF_ENABLE0, wsel[i] == 0 ? 16'h1 << wbit[i] : 16'h0);
            wr(OFF_ENABLE1, wsel[i] == 1 ? 16'h1 << wbit[i] : 16'h0);
            settle();
            chk8(irq_req_out, 8'h1 << i);
            chk8(irq_req_out & 8'h9c, (8'h1 << i) & 8'h9c);
            chk8({7'h0, irq}, 8'h00);
        end
        level_cmd <= 8'h00;
        rd(OFF_STATUS, 16'h00ff);
        rd(OFF_STATUS, 16'h0000);
        // Events on enabled sources reach the summary only when masked in.
        wr(OFF_ENABLE0, 16'h0003);
        wr(OFF_ENABLE1, 16'h201f);
        wr(OFF_MASK, 16'h0080);
        rd(OFF_MASK, 16'h0080);
        level_cmd <= 8'h02;
        settle();
        chk8(irq_req_out, 8'h02);
        chk8({7'h0, irq}, 8'h00);
        level_cmd <= 8'h82;
        settle();
        chk8({7'h0, irq}, 8'h01);
        rd(OFF_STATUS, 16'h0082);
        chk8({7'h0, irq}, 8'h00);
        rd(OFF_STATUS, 16'h0000);
        chk8({7'h0, irq_cycles > 0}, 8'h01);
        // Set wins: an edge that lands in the clearing read stays set.
        level_cmd <= 8'h83;
        @(posedge clk_sys);
        rd(OFF_STATUS, 16'h0000);
        rd(OFF_STATUS, 16'h0001);
        chk8({7'h0, stray_cycles != 0}, 8'h00);
        // A reset in mid-run drops every enable written so far.
        @(posedge clk_sys);
        reset <= 1'b1;
        repeat (2) @(posedge clk_sys);
        reset <= 1'b0;
        rd(OFF_ENABLE0, 16'h0000);
        rd(OFF_ENABLE1, 16'h0000);
        rd(OFF_MASK, 16'h0000);
        rd(OFF_STATUS, 16'h0000);
        final_report();
    end
endmodule
